// ---- logic/rsa_core.sv ----
// Purpose: Combinational result, flag and skip computation
// Assumes: Operands stable for the whole machine cycle
// Notes:   No state; all storage lives in the top module
`timescale 1ns/1ps
module rsa_core (
	input  wire rsa_pkg::rsa_op_t op,         // Decoded operation
	input  wire logic [7:0]       mem_data,   // Addressed data memory byte
	input  wire logic [7:0]       acc,        // Accumulator
	input  wire logic [7:0]       imm,        // Immediate constant
	input  wire logic [2:0]       bit_sel,    // Selected bit position
	input  wire logic             carry_in,   // Current carry flag
	rsa_res_if.core               res         // Result bundle
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// acc + b + cin with all four arithmetic flags
	function automatic logic [11:0] add_flags(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [8:0] s;
		logic [4:0] lo;
		logic       ov;
		s  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		ov = (a[rsa_pkg::MSB] == b[rsa_pkg::MSB]) && (s[rsa_pkg::MSB] != a[rsa_pkg::MSB]);
		add_flags = {ov, (s[7:0] == rsa_pkg::ZERO_BYTE), lo[4], s[8], s[7:0]};
	endfunction

	logic [11:0] sum;
	logic [7:0]  inc_val;
	logic [7:0]  dec_val;
	logic [7:0]  bit_mask;

	always_comb begin
		case (op)
			rsa_pkg::rsa_op_subtract_borrow_to_acc,
			rsa_pkg::rsa_op_subtract_borrow_to_mem: begin
				sum = add_flags(acc, ~mem_data, carry_in);
			end
			rsa_pkg::rsa_op_subtract_immediate: begin
				sum = add_flags(acc, ~imm, 1'b1);
			end
			default: begin
				sum = add_flags(acc, ~mem_data, 1'b1);
			end
		endcase
	end

	assign inc_val  = mem_data + rsa_pkg::ONE_BYTE;
	assign dec_val  = mem_data - rsa_pkg::ONE_BYTE;
	assign bit_mask = rsa_pkg::ONE_BYTE << bit_sel;

	// ----------------------------------------
	// Result select
	// ----------------------------------------
	always_comb begin
		res.result    = mem_data;
		res.wr_mem    = 1'b0;
		res.wr_acc    = 1'b0;
		res.wr_carry  = 1'b0;
		res.carry     = carry_in;
		res.wr_arith  = 1'b0;
		res.overflow  = sum[11];
		res.zero      = sum[10];
		res.aux_carry = sum[9];
		res.skip      = 1'b0;
		case (op)
			rsa_pkg::rsa_op_rotate_left_thru_carry,
			rsa_pkg::rsa_op_rotate_left_thru_carry_to_acc: begin
				res.result   = {mem_data[6:0], carry_in};
				res.wr_carry = 1'b1;
				res.carry    = mem_data[rsa_pkg::MSB];
				res.wr_mem   = (op == rsa_pkg::rsa_op_rotate_left_thru_carry);
				res.wr_acc   = !res.wr_mem;
			end
			rsa_pkg::rsa_op_rotate_right_plain,
			rsa_pkg::rsa_op_rotate_right_to_acc: begin
				res.result = {mem_data[0], mem_data[7:1]};
				res.wr_mem = (op == rsa_pkg::rsa_op_rotate_right_plain);
				res.wr_acc = !res.wr_mem;
			end
			rsa_pkg::rsa_op_rotate_right_thru_carry,
			rsa_pkg::rsa_op_rotate_right_thru_carry_to_acc: begin
				res.result   = {carry_in, mem_data[7:1]};
				res.wr_carry = 1'b1;
				res.carry    = mem_data[0];
				res.wr_mem   = (op == rsa_pkg::rsa_op_rotate_right_thru_carry);
				res.wr_acc   = !res.wr_mem;
			end
			rsa_pkg::rsa_op_subtract_borrow_to_acc,
			rsa_pkg::rsa_op_subtract_to_acc,
			rsa_pkg::rsa_op_subtract_immediate: begin
				res.result   = sum[7:0];
				res.wr_acc   = 1'b1;
				res.wr_arith = 1'b1;
				res.wr_carry = 1'b1;
				res.carry    = sum[8];
			end
			rsa_pkg::rsa_op_subtract_borrow_to_mem,
			rsa_pkg::rsa_op_subtract_to_mem: begin
				res.result   = sum[7:0];
				res.wr_mem   = 1'b1;
				res.wr_arith = 1'b1;
				res.wr_carry = 1'b1;
				res.carry    = sum[8];
			end
			rsa_pkg::rsa_op_decrement_skip_zero,
			rsa_pkg::rsa_op_decrement_to_acc_skip_zero: begin
				res.result = dec_val;
				res.wr_mem = (op == rsa_pkg::rsa_op_decrement_skip_zero);
				res.wr_acc = !res.wr_mem;
				res.skip   = (dec_val == rsa_pkg::ZERO_BYTE);
			end
			rsa_pkg::rsa_op_increment_skip_zero,
			rsa_pkg::rsa_op_increment_to_acc_skip_zero: begin
				res.result = inc_val;
				res.wr_mem = (op == rsa_pkg::rsa_op_increment_skip_zero);
				res.wr_acc = !res.wr_mem;
				res.skip   = (inc_val == rsa_pkg::ZERO_BYTE);
			end
			rsa_pkg::rsa_op_set_byte: begin
				res.result = rsa_pkg::ALL_ONES;
				res.wr_mem = 1'b1;
			end
			rsa_pkg::rsa_op_set_bit: begin
				res.result = mem_data | bit_mask;
				res.wr_mem = 1'b1;
			end
			rsa_pkg::rsa_op_skip_bit_nonzero: begin
				res.skip = |(mem_data & bit_mask);
			end
			rsa_pkg::rsa_op_nibble_exchange,
			rsa_pkg::rsa_op_nibble_exchange_to_acc: begin
				res.result = {mem_data[rsa_pkg::NIB_LO_TOP:0],
					mem_data[rsa_pkg::MSB:rsa_pkg::NIB_HI_BOT]};
				res.wr_mem = (op == rsa_pkg::rsa_op_nibble_exchange);
				res.wr_acc = !res.wr_mem;
			end
			default: begin
				res.result = mem_data;
			end
		endcase
	end
endmodule // rsa_core

// ---- logic/rsa_pkg.sv ----
// Purpose: Shared constants and types for the rotate/subtract/skip datapath
// Assumes: 8-bit data memory byte, 8-bit accumulator
// Notes:   Operation codes are arbitrary encodings chosen for the decoder
package rsa_pkg;
	localparam int DATA_W = 8;
	localparam int BIT_SEL_W = 3;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int MSB = 7;
	localparam int NIB_LO_TOP = 3;
	localparam int NIB_HI_BOT = 4;
	localparam int SKIP_CYCLES = 2;
	localparam int NORMAL_CYCLES = 1;

	typedef enum logic [4:0] {
		rsa_op_nop,
		rsa_op_rotate_left_thru_carry,
		rsa_op_rotate_left_thru_carry_to_acc,
		rsa_op_rotate_right_plain,
		rsa_op_rotate_right_to_acc,
		rsa_op_rotate_right_thru_carry,
		rsa_op_rotate_right_thru_carry_to_acc,
		rsa_op_subtract_borrow_to_acc,
		rsa_op_subtract_borrow_to_mem,
		rsa_op_decrement_skip_zero,
		rsa_op_decrement_to_acc_skip_zero,
		rsa_op_increment_skip_zero,
		rsa_op_increment_to_acc_skip_zero,
		rsa_op_set_byte,
		rsa_op_set_bit,
		rsa_op_skip_bit_nonzero,
		rsa_op_subtract_to_acc,
		rsa_op_subtract_to_mem,
		rsa_op_subtract_immediate,
		rsa_op_nibble_exchange,
		rsa_op_nibble_exchange_to_acc
	} rsa_op_t;
endpackage

// ---- logic/rsa_res_if.sv ----
// Purpose: Carries one combinational datapath result to the register stage
// Assumes: Single clock
// Notes:   Produced by the core, consumed by the top
`timescale 1ns/1ps
interface rsa_res_if;
	logic [7:0] result;
	logic       wr_mem;
	logic       wr_acc;
	logic       wr_carry;
	logic       carry;
	logic       wr_arith;
	logic       overflow;
	logic       zero;
	logic       aux_carry;
	logic       skip;
	modport core (output result, wr_mem, wr_acc, wr_carry, carry, wr_arith,
		overflow, zero, aux_carry, skip);
	modport top (input result, wr_mem, wr_acc, wr_carry, carry, wr_arith,
		overflow, zero, aux_carry, skip);
endinterface

// ---- logic/rsa_alu.sv ----
// Purpose: Rotate, subtract, set, swap and skip datapath of an 8-bit core
// Assumes: One instruction presented per machine cycle with instr_valid
// Notes:   Skip discards the prefetched instruction with one dummy cycle
`timescale 1ns/1ps
module rsa_alu #(
	parameter int DATA_W = rsa_pkg::DATA_W  // Datapath width
) (
	input  wire logic             clk,          // Machine cycle clock
	input  wire logic             rst,          // Synchronous reset, active high
	input  wire logic             instr_valid,  // Instruction present this cycle
	input  wire rsa_pkg::rsa_op_t op,           // Decoded operation
	input  wire logic [7:0]       mem_rdata,    // Addressed memory byte
	input  wire logic [7:0]       imm,          // Immediate constant
	input  wire logic [2:0]       bit_sel,      // Bit position
	output logic [7:0]            mem_wdata,    // Write-back byte
	output logic                  mem_we,       // Memory write pulse
	output logic [7:0]            acc,          // Accumulator
	output logic                  carry_flag,   // Carry flag
	output logic                  zero_flag,    // Zero flag
	output logic                  overflow_flag,// Overflow flag
	output logic                  aux_carry_flag,// Auxiliary carry flag
	output logic                  discard,      // Prefetched instruction dropped
	output logic                  busy          // Dummy cycle in progress
);
	rsa_res_if res ();
	logic take;

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	rsa_core u_core (
		.op       (op),
		.mem_data (mem_rdata),
		.acc      (acc),
		.imm      (imm),
		.bit_sel  (bit_sel),
		.carry_in (carry_flag),
		.res      (res)
	);

	// Decoder must hold off during the dummy cycle
	assign take = instr_valid && !busy;

	// ----------------------------------------
	// Memory write port
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_wdata <= rsa_pkg::ZERO_BYTE;
			mem_we    <= 1'b0;
		end else begin
			mem_we <= take && res.wr_mem;
			if (take && res.wr_mem) begin
				mem_wdata <= res.result;
			end
		end
	end

	// ----------------------------------------
	// Accumulator
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			acc <= rsa_pkg::ZERO_BYTE;
		end else if (take && res.wr_acc) begin
			acc <= res.result;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Set, swap and skip forms leave flags alone
	always_ff @(posedge clk) begin
		if (rst) begin
			carry_flag <= 1'b0;
		end else if (take && res.wr_carry) begin
			carry_flag <= res.carry;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			zero_flag      <= 1'b0;
			overflow_flag  <= 1'b0;
			aux_carry_flag <= 1'b0;
		end else if (take && res.wr_arith) begin
			zero_flag      <= res.zero;
			overflow_flag  <= res.overflow;
			aux_carry_flag <= res.aux_carry;
		end
	end

	// ----------------------------------------
	// Skip sequencing
	// ----------------------------------------
	// One dummy cycle replaces the discarded prefetch
	always_ff @(posedge clk) begin
		if (rst) begin
			busy    <= 1'b0;
			discard <= 1'b0;
		end else begin
			busy    <= take && res.skip;
			discard <= take && res.skip;
		end
	end
endmodule // rsa_alu

// ---- sim/rsa_alu_chk.sv ----
// Purpose: Port-level assertions for the rotate/subtract/skip datapath
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every rsa_alu instance
`timescale 1ns/1ps
module rsa_alu_chk (
	input wire logic             clk,         // Clock
	input wire logic             rst,         // Reset
	input wire logic             instr_valid, // Request
	input wire rsa_pkg::rsa_op_t op,          // Operation
	input wire logic [7:0]       mem_rdata,   // Operand
	input wire logic [2:0]       bit_sel,     // Bit index
	input wire logic [7:0]       mem_wdata,   // Write byte
	input wire logic             mem_we,      // Write pulse
	input wire logic [7:0]       acc,         // Accumulator
	input wire logic             carry_flag,  // Carry
	input wire logic             discard,     // Drop pulse
	input wire logic             busy         // Dummy cycle
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire go      = instr_valid && !busy;
	wire sel_bit = mem_rdata[bit_sel];
	a_rotate_left_mem: assert property (go && op == rsa_pkg::rsa_op_rotate_left_thru_carry |=>
		mem_we && mem_wdata == {$past(mem_rdata[6:0]), $past(carry_flag)}
		&& carry_flag == $past(mem_rdata[7])) else $error("rotate left wrong");
	a_rotate_right_acc: assert property (go && op == rsa_pkg::rsa_op_rotate_right_to_acc |=>
		!mem_we && acc == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}) else $error("rotate acc wrong");
	a_sub_to_acc: assert property (go && op == rsa_pkg::rsa_op_subtract_to_acc |=>
		acc == 8'($past(acc) + ~$past(mem_rdata) + 8'h01)) else $error("subtract wrong");
	a_sub_to_mem: assert property (go && op == rsa_pkg::rsa_op_subtract_to_mem |=>
		mem_we && mem_wdata == 8'($past(acc) + ~$past(mem_rdata) + 8'h01) && $stable(acc))
		else $error("subtract to memory wrong");
	a_set_byte_ones: assert property (go && op == rsa_pkg::rsa_op_set_byte |=>
		mem_we && mem_wdata == 8'hFF && $stable(carry_flag)) else $error("set byte wrong");
	a_set_bit_one: assert property (go && op == rsa_pkg::rsa_op_set_bit |=>
		mem_we && mem_wdata == ($past(mem_rdata) | (8'h01 << $past(bit_sel)))) else $error("set bit wrong");
	a_inc_skip_zero: assert property (go && op == rsa_pkg::rsa_op_increment_skip_zero |=>
		mem_we && mem_wdata == 8'($past(mem_rdata) + 8'h01)
		&& busy == ($past(mem_rdata) == 8'hFF)) else $error("increment skip wrong");
	a_bit_skip_test: assert property (go && op == rsa_pkg::rsa_op_skip_bit_nonzero |=>
		!mem_we && busy == $past(sel_bit)) else $error("bit skip wrong");
	a_dummy_one_cycle: assert property (busy |=> !busy && !mem_we && $stable(acc))
		else $error("dummy cycle wrong");
	a_discard_with_busy: assert property (discard == busy) else $error("discard wrong");
	c_skip_taken: cover property (go && op == rsa_pkg::rsa_op_increment_skip_zero ##1 busy);
	c_bit_skip: cover property (go && op == rsa_pkg::rsa_op_skip_bit_nonzero ##1 busy);
	c_refused: cover property (busy && instr_valid);
endmodule // rsa_alu_chk

bind rsa_alu rsa_alu_chk rsa_alu_chk_inst (.clk, .rst, .instr_valid, .op, .mem_rdata, .bit_sel,
	.mem_wdata, .mem_we, .acc, .carry_flag, .discard, .busy);

// ---- sim/test_mcu_rotate_subtract_skip_alu.sv ----
// Purpose: Directed bench for the rotate/subtract/skip datapath
// Assumes: Inputs change on the falling edge
// Notes:   Immediate is the complement of the memory operand, so a mixed-up source shows
`timescale 1ns/1ps
module test_mcu_rotate_subtract_skip_alu;
	logic             clk, rst, instr_valid, mem_we, carry_flag, zero_flag;
	logic             overflow_flag, aux_carry_flag, discard, busy;
	rsa_pkg::rsa_op_t op;
	logic [7:0]       mem_rdata, imm, mem_wdata, acc;
	logic [2:0]       bit_sel;
	int               bad_count, comparisons;
	rsa_alu rsa_alu_inst (.clk, .rst, .instr_valid, .op, .mem_rdata, .imm, .bit_sel, .mem_wdata,
		.mem_we, .acc, .carry_flag, .zero_flag, .overflow_flag, .aux_carry_flag, .discard, .busy);
	task cmp8(input string n, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task cmp1(input string n, input logic e, g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task conclude;
		if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Skips also offer a set-byte during the dummy cycle, which must be ignored
	task step(input rsa_pkg::rsa_op_t o, input logic [7:0] m, input logic [2:0] b,
		input logic we, input logic [7:0] wd, a, input logic c, sk);
		@(negedge clk);
		op = o;
		mem_rdata = m;
		imm = ~m;
		bit_sel = b;
		instr_valid = 1'h1;
		@(negedge clk);
		cmp1("mem_we", we, mem_we);
		if (we) cmp8("mem_wdata", wd, mem_wdata);
		cmp8("acc", a, acc);
		cmp1("carry", c, carry_flag);
		cmp1("busy", sk, busy);
		cmp1("discard", sk, discard);
		if (sk) begin
			op = rsa_pkg::rsa_op_set_byte;
			@(negedge clk);
			cmp1("refused_we", 1'h0, mem_we);
			cmp1("busy_end", 1'h0, busy);
		end
		instr_valid = 1'h0;
	endtask
	task flg(input logic z, ov, ac);
		cmp1("zero", z, zero_flag);
		cmp1("overflow", ov, overflow_flag);
		cmp1("aux_carry", ac, aux_carry_flag);
	endtask
	task t_rotate;
		step(rsa_pkg::rsa_op_rotate_left_thru_carry, 8'hAA, 3'h0, 1'h1, 8'h54, 8'h00, 1'h1, 1'h0);
		step(rsa_pkg::rsa_op_rotate_left_thru_carry_to_acc, 8'h01, 3'h0, 1'h0, 8'h00, 8'h03, 1'h0, 1'h0);
		step(rsa_pkg::rsa_op_rotate_right_plain, 8'h01, 3'h0, 1'h1, 8'h80, 8'h03, 1'h0, 1'h0);
		step(rsa_pkg::rsa_op_rotate_right_to_acc, 8'h02, 3'h0, 1'h0, 8'h00, 8'h01, 1'h0, 1'h0);
		step(rsa_pkg::rsa_op_rotate_right_thru_carry, 8'h01, 3'h0, 1'h1, 8'h00, 8'h01, 1'h1, 1'h0);
		step(rsa_pkg::rsa_op_rotate_right_thru_carry_to_acc, 8'h00, 3'h0, 1'h0, 8'h00, 8'h80, 1'h0, 1'h0);
	endtask
	task t_subtract;
		step(rsa_pkg::rsa_op_subtract_borrow_to_acc, 8'h00, 3'h0, 1'h0, 8'h00, 8'h7F, 1'h1, 1'h0);
		flg(1'h0, 1'h1, 1'h0);
		step(rsa_pkg::rsa_op_subtract_borrow_to_mem, 8'h7F, 3'h0, 1'h1, 8'h00, 8'h7F, 1'h1, 1'h0);
		flg(1'h1, 1'h0, 1'h1);
		step(rsa_pkg::rsa_op_subtract_to_acc, 8'h01, 3'h0, 1'h0, 8'h00, 8'h7E, 1'h1, 1'h0);
		flg(1'h0, 1'h0, 1'h1);
		step(rsa_pkg::rsa_op_subtract_immediate, 8'h00, 3'h0, 1'h0, 8'h00, 8'h7F, 1'h0, 1'h0);
		flg(1'h0, 1'h0, 1'h0);
		step(rsa_pkg::rsa_op_subtract_to_mem, 8'h7F, 3'h0, 1'h1, 8'h00, 8'h7F, 1'h1, 1'h0);
		flg(1'h1, 1'h0, 1'h1);
	endtask
	task t_skip;
		// Carry, zero and aux carry are set here, so any stray write to them shows
		step(rsa_pkg::rsa_op_increment_skip_zero, 8'hFF, 3'h0, 1'h1, 8'h00, 8'h7F, 1'h1, 1'h1);
		step(rsa_pkg::rsa_op_increment_skip_zero, 8'hFE, 3'h0, 1'h1, 8'hFF, 8'h7F, 1'h1, 1'h0);
		step(rsa_pkg::rsa_op_increment_to_acc_skip_zero, 8'hFF, 3'h0, 1'h0, 8'h00, 8'h00, 1'h1, 1'h1);
		step(rsa_pkg::rsa_op_decrement_skip_zero, 8'h01, 3'h0, 1'h1, 8'h00, 8'h00, 1'h1, 1'h1);
		step(rsa_pkg::rsa_op_decrement_to_acc_skip_zero, 8'h00, 3'h0, 1'h0, 8'h00, 8'hFF, 1'h1, 1'h0);
		step(rsa_pkg::rsa_op_skip_bit_nonzero, 8'h08, 3'h3, 1'h0, 8'h00, 8'hFF, 1'h1, 1'h1);
		step(rsa_pkg::rsa_op_skip_bit_nonzero, 8'hF7, 3'h3, 1'h0, 8'h00, 8'hFF, 1'h1, 1'h0);
		flg(1'h1, 1'h0, 1'h1);
	endtask
	task t_set_swap;
		step(rsa_pkg::rsa_op_set_byte, 8'h00, 3'h0, 1'h1, 8'hFF, 8'hFF, 1'h1, 1'h0);
		flg(1'h1, 1'h0, 1'h1);
		step(rsa_pkg::rsa_op_set_bit, 8'h00, 3'h7, 1'h1, 8'h80, 8'hFF, 1'h1, 1'h0);
		flg(1'h1, 1'h0, 1'h1);
		step(rsa_pkg::rsa_op_nibble_exchange, 8'hA5, 3'h0, 1'h1, 8'h5A, 8'hFF, 1'h1, 1'h0);
		step(rsa_pkg::rsa_op_nibble_exchange_to_acc, 8'h3C, 3'h0, 1'h0, 8'h00, 8'hC3, 1'h1, 1'h0);
		flg(1'h1, 1'h0, 1'h1);
	endtask
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#2000;
		bad_count++;
		conclude();
	end
	initial begin
		rst = 1'h1;
		instr_valid = 1'h0;
		op = rsa_pkg::rsa_op_nop;
		mem_rdata = 8'h00;
		imm = 8'h00;
		bit_sel = 3'h0;
		repeat (10) @(negedge clk);
		rst = 1'h0;
		cmp8("acc_reset", 8'h00, acc);
		cmp1("carry_reset", 1'h0, carry_flag);
		t_rotate();
		t_subtract();
		t_skip();
		t_set_swap();
		conclude();
	end
endmodule // test_mcu_rotate_subtract_skip_alu
